// ==== common/csb_pkg.sv ====
// Constants, register map and carrier types for the CAN status, event and bit-timing block
package csb_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    // Register offsets
    localparam logic [3:0] OFS_FIFO_STATUS = 4'h0;
    localparam logic [3:0] OFS_EVENT_FLAGS = 4'h1;
    localparam logic [3:0] OFS_EVENT_ENABLES = 4'h2;
    localparam logic [3:0] OFS_ERROR_COUNTERS = 4'h3;
    localparam logic [3:0] OFS_BIT_TIMING_ONE = 4'h4;
    localparam logic [3:0] OFS_CLOCK_CONTROL = 4'h5;
    // Field positions
    localparam int POS_WRITE_PTR = 8;
    localparam int POS_READ_PTR = 0;
    localparam int POS_TX_BUS_OFF = 13;
    localparam int POS_ERROR_FLAG = 5;
    localparam int POS_JUMP = 6;
    localparam int POS_CLOCK_SELECT = 11;
    // Implemented event flag bits 7,6,5,3,2,1,0
    localparam logic [7:0] EVENT_MASK = 8'hEF;
    // Reset values
    localparam logic [7:0] RST_FLAGS = 8'h00;
    localparam logic [7:0] RST_ENABLES = 8'h00;
    localparam logic [7:0] RST_TIMING = 8'h00;
    localparam logic RST_CLOCK_SELECT = 1'b0;

    // Error state from the protocol engine
    typedef struct packed {
        logic tx_bus_off_state;
        logic tx_error_passive_state;
        logic rx_error_passive_state;
        logic tx_warning_state;
        logic rx_warning_state;
    } csb_err_state_type;

    // One-cycle event pulses from the protocol engine and buffer logic
    typedef struct packed {
        logic invalid_msg;
        logic wakeup;
        logic fifo_almost_full;
        logic rx_overflow;
        logic rx_buffer;
        logic tx_buffer;
    } csb_events_type;

    // Timing settings handed to the bit-timing logic
    typedef struct packed {
        logic [2:0] jump_quanta;
        logic [7:0] quantum_clocks;
        logic module_clock_select;
    } csb_timing_type;
endpackage : csb_pkg

// ==== src/csb_status_regs.sv ====
// Status, event flag, enable, error counter and bit-timing registers of the CAN block
//
// The address map and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
module csb_status_regs (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Register port
    input wire logic [csb_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [csb_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [csb_pkg::DATA_W-1:0] reg_rdata,
    // Engine status
    input wire logic [5:0] fifo_write_pointer,
    input wire logic [5:0] fifo_next_read_pointer,
    input wire csb_pkg::csb_err_state_type err_state,
    input wire logic [7:0] tx_error_counter,
    input wire logic [7:0] rx_error_counter,
    input wire csb_pkg::csb_events_type events,
    // Outputs to the engine and interrupt controller
    output csb_pkg::csb_timing_type timing,
    output logic irq
);
    import csb_pkg::*;

    // Register state and the next value of each group
    logic [7:0] flags;
    logic [7:0] next_flags;
    logic [7:0] enables;
    logic [7:0] next_enables;
    logic [7:0] bit_timing;
    logic [7:0] next_bit_timing;
    logic clock_select;
    logic next_clock_select;
    logic [5:0] err_bits_prev;
    logic [5:0] next_err_bits_prev;
    logic [DATA_W-1:0] next_rdata;

    // Event and error helpers
    logic [5:0] err_bits;
    logic [5:0] err_rise;
    logic [7:0] set_vec;
    logic [7:0] clear_vec;

    // Error state under its register names
    logic tx_bus_off_state;
    logic tx_error_passive_state;
    logic rx_error_passive_state;
    logic tx_warning_state;
    logic rx_warning_state;
    logic any_warning_state;

    // Flag bits under their own names
    logic invalid_msg_flag;
    logic wakeup_flag;
    logic error_event_flag;
    logic fifo_almost_full_flag;
    logic rx_overflow_flag;
    logic rx_buffer_flag;
    logic tx_buffer_flag;

    // Enable bits under their own names
    logic invalid_msg_enable;
    logic wakeup_enable;
    logic error_event_enable;
    logic fifo_almost_full_enable;
    logic rx_overflow_enable;
    logic rx_buffer_enable;
    logic tx_buffer_enable;

    // Decoded strobes
    logic wr_flags;
    logic wr_enables;
    logic wr_timing;
    logic wr_clock;
    logic rd_fifo;
    logic rd_flags;
    logic rd_enables;
    logic rd_counts;
    logic rd_timing;
    logic rd_clock;

    // Read words before the output mux
    logic [DATA_W-1:0] fifo_word;
    logic [DATA_W-1:0] flag_word;
    logic [DATA_W-1:0] enable_word;
    logic [DATA_W-1:0] count_word;
    logic [DATA_W-1:0] timing_word;
    logic [DATA_W-1:0] clock_word;

    // Fields of the bit-timing register
    logic [1:0] resync_jump_width;
    logic [5:0] baud_prescaler;

    // Address match shared by the write and read decoders
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [3:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    // An eight-bit register reads in the low byte, upper byte zero
    function automatic logic [DATA_W-1:0] low_byte(input logic [7:0] v);
        low_byte = {8'h00, v};
    endfunction : low_byte

    // Jump width in quanta is the field plus one
    function automatic logic [2:0] jump_span(input logic [1:0] field);
        jump_span = {1'b0, field} + 3'h1;
    endfunction : jump_span

    // Quantum length in module clocks, 2 up to 128
    function automatic logic [7:0] quantum_span(input logic [5:0] field);
        quantum_span = {1'b0, field, 1'b0} + 8'h02;
    endfunction : quantum_span

    // Write strobes; writes to read-only or unmapped offsets fall through
    always_comb begin
        wr_flags = 1'b0;
        wr_enables = 1'b0;
        wr_timing = 1'b0;
        wr_clock = 1'b0;
        if (reg_write) begin
            wr_flags = hit(reg_addr, OFS_EVENT_FLAGS);
            wr_enables = hit(reg_addr, OFS_EVENT_ENABLES);
            wr_timing = hit(reg_addr, OFS_BIT_TIMING_ONE);
            wr_clock = hit(reg_addr, OFS_CLOCK_CONTROL);
        end
    end

    // Read strobes; an unmapped offset selects nothing and reads zero
    always_comb begin
        rd_fifo = 1'b0;
        rd_flags = 1'b0;
        rd_enables = 1'b0;
        rd_counts = 1'b0;
        rd_timing = 1'b0;
        rd_clock = 1'b0;
        if (reg_read) begin
            rd_fifo = hit(reg_addr, OFS_FIFO_STATUS);
            rd_flags = hit(reg_addr, OFS_EVENT_FLAGS);
            rd_enables = hit(reg_addr, OFS_EVENT_ENABLES);
            rd_counts = hit(reg_addr, OFS_ERROR_COUNTERS);
            rd_timing = hit(reg_addr, OFS_BIT_TIMING_ONE);
            rd_clock = hit(reg_addr, OFS_CLOCK_CONTROL);
        end
    end

    // Error state of the engine under its register names
    always_comb begin
        tx_bus_off_state = err_state.tx_bus_off_state;
        tx_error_passive_state = err_state.tx_error_passive_state;
        rx_error_passive_state = err_state.rx_error_passive_state;
        tx_warning_state = err_state.tx_warning_state;
        rx_warning_state = err_state.rx_warning_state;
        any_warning_state = tx_warning_state | rx_warning_state;
    end

    // Status bits 13:8, shared by the read word and the edge detector
    always_comb begin
        err_bits[5] = tx_bus_off_state;
        err_bits[4] = tx_error_passive_state;
        err_bits[3] = rx_error_passive_state;
        err_bits[2] = tx_warning_state;
        err_bits[1] = rx_warning_state;
        err_bits[0] = any_warning_state;
    end

    // Rising edge per state bit so a steady condition flags only once
    for (genvar b = 0; b < 6; b++) begin : g_err_rise
        assign err_rise[b] = err_bits[b] & ~err_bits_prev[b];
    end

    // Hardware set requests, one per implemented flag
    always_comb begin
        // Event pulses last one cycle; the flag holds them for software
        set_vec = 8'h00;
        set_vec[7] = events.invalid_msg;
        set_vec[6] = events.wakeup;
        set_vec[POS_ERROR_FLAG] = |err_rise;
        set_vec[3] = events.fifo_almost_full;
        set_vec[2] = events.rx_overflow;
        set_vec[1] = events.rx_buffer;
        set_vec[0] = events.tx_buffer;
    end

    // A written zero clears its flag; a written one leaves it alone
    for (genvar f = 0; f < 8; f++) begin : g_flag_clear
        assign clear_vec[f] = wr_flags & ~reg_wdata[f];
    end

    // Clear first, then set, so an event in the clearing cycle survives
    always_comb begin
        next_flags = flags & ~clear_vec;
        next_flags = next_flags | set_vec;
        next_flags = next_flags & EVENT_MASK;
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            flags <= RST_FLAGS;
        end else begin
            flags <= next_flags;
        end
    end

    // Enables: only implemented positions take a written one
    always_comb begin
        next_enables = enables;
        if (wr_enables) begin
            // Bit 4 cannot be enabled; it has no flag
            next_enables = reg_wdata[7:0] & EVENT_MASK;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            enables <= RST_ENABLES;
        end else begin
            enables <= next_enables;
        end
    end

    // Bit-timing register; the upper byte is not implemented
    always_comb begin
        next_bit_timing = bit_timing;
        if (wr_timing) begin
            // Meant for an idle engine; a change mid-frame is not guarded
            next_bit_timing = reg_wdata[7:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            bit_timing <= RST_TIMING;
        end else begin
            bit_timing <= next_bit_timing;
        end
    end

    // Module clock select
    always_comb begin
        next_clock_select = clock_select;
        if (wr_clock) begin
            // Takes effect at once; the engine owns the clock switch itself
            next_clock_select = reg_wdata[POS_CLOCK_SELECT];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            clock_select <= RST_CLOCK_SELECT;
        end else begin
            clock_select <= next_clock_select;
        end
    end

    // Previous error state for the edge detector
    // Zero after reset, so a state present at release flags once
    always_comb begin
        next_err_bits_prev = err_bits;
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            err_bits_prev <= 6'h00;
        end else begin
            err_bits_prev <= next_err_bits_prev;
        end
    end

    // Read words, each with its unimplemented bits held at zero
    always_comb begin
        fifo_word = '0;
        fifo_word[POS_WRITE_PTR +: 6] = fifo_write_pointer;
        fifo_word[POS_READ_PTR +: 6] = fifo_next_read_pointer;
    end

    always_comb begin
        flag_word = '0;
        flag_word[POS_TX_BUS_OFF -: 6] = err_bits;
        flag_word[7:0] = flags;
    end

    always_comb begin
        clock_word = '0;
        clock_word[POS_CLOCK_SELECT] = clock_select;
    end

    assign enable_word = low_byte(enables);
    // The error counters are live levels, not captured copies
    assign count_word = {tx_error_counter, rx_error_counter};
    assign timing_word = low_byte(bit_timing);

    // Read data mux; nothing selected returns zero
    always_comb begin
        // Strobes are one-hot, so at most one word is picked
        next_rdata = '0;
        if (rd_fifo) begin
            next_rdata = fifo_word;
        end
        if (rd_flags) begin
            next_rdata = flag_word;
        end
        if (rd_enables) begin
            next_rdata = enable_word;
        end
        if (rd_counts) begin
            next_rdata = count_word;
        end
        if (rd_timing) begin
            next_rdata = timing_word;
        end
        if (rd_clock) begin
            next_rdata = clock_word;
        end
    end

    // Read data stands for one cycle after the strobe, zero otherwise
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

    // Field split of the bit-timing register
    always_comb begin
        resync_jump_width = bit_timing[POS_JUMP +: 2];
        baud_prescaler = bit_timing[5:0];
    end

    // Settings handed to the engine
    always_comb begin
        timing.jump_quanta = jump_span(resync_jump_width);
        timing.quantum_clocks = quantum_span(baud_prescaler);
        // Engine doubles its clock when set
        timing.module_clock_select = clock_select;
    end

    // Flag bits under their own names
    always_comb begin
        invalid_msg_flag = flags[7];
        wakeup_flag = flags[6];
        error_event_flag = flags[POS_ERROR_FLAG];
        fifo_almost_full_flag = flags[3];
        rx_overflow_flag = flags[2];
        rx_buffer_flag = flags[1];
        tx_buffer_flag = flags[0];
    end

    // Enable bits under their own names
    always_comb begin
        invalid_msg_enable = enables[7];
        wakeup_enable = enables[6];
        error_event_enable = enables[POS_ERROR_FLAG];
        fifo_almost_full_enable = enables[3];
        rx_overflow_enable = enables[2];
        rx_buffer_enable = enables[1];
        tx_buffer_enable = enables[0];
    end

    // Combined request; bit 4 has no flag and so no term
    always_comb begin
        irq = (invalid_msg_flag & invalid_msg_enable)
            | (wakeup_flag & wakeup_enable)
            | (error_event_flag & error_event_enable)
            | (fifo_almost_full_flag & fifo_almost_full_enable)
            | (rx_overflow_flag & rx_overflow_enable)
            | (rx_buffer_flag & rx_buffer_enable)
            | (tx_buffer_flag & tx_buffer_enable);
    end
endmodule : csb_status_regs

// ==== tb/csb_status_regs_asserts.sv ====
// Checker on the register port and timing outputs of the status block
`timescale 1ns/1ps
module csb_status_regs_asserts import csb_pkg::*; (
    input wire logic sys_clk, reset, reg_write, reg_read, irq,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata, reg_rdata,
    input wire logic [5:0] fifo_write_pointer, fifo_next_read_pointer,
    input wire logic [7:0] tx_error_counter, rx_error_counter,
    input wire csb_err_state_type err_state,
    input wire csb_events_type events,
    input wire csb_timing_type timing
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    chk_fifo_read: assert property (reg_read && reg_addr == OFS_FIFO_STATUS |=>
        reg_rdata == {2'h0, $past(fifo_write_pointer), 2'h0, $past(fifo_next_read_pointer)})
        else $error("fifo status read wrong");
    chk_state_bits: assert property (reg_read && reg_addr == OFS_EVENT_FLAGS |=>
        reg_rdata[15:8] == {2'h0, $past(err_state), |$past(err_state[1:0])} && !reg_rdata[4])
        else $error("error state bits wrong");
    chk_count_read: assert property (reg_read && reg_addr == OFS_ERROR_COUNTERS |=>
        reg_rdata == {$past(tx_error_counter), $past(rx_error_counter)})
        else $error("error counter read wrong");
    chk_rdata_idle: assert property (!reg_read |=> reg_rdata == 16'h0000)
        else $error("read data not zero outside read");
    chk_unmapped_zero: assert property (reg_read && reg_addr > OFS_CLOCK_CONTROL |=>
        reg_rdata == 16'h0000) else $error("unmapped read not zero");
    chk_timing_write: assert property (reg_write && reg_addr == OFS_BIT_TIMING_ONE |=>
        timing.jump_quanta == 3'($past(reg_wdata[7:6])) + 3'h1 &&
        timing.quantum_clocks == {1'b0, $past(reg_wdata[5:0]), 1'b0} + 8'h02)
        else $error("timing outputs wrong");
    chk_clock_select: assert property (reg_write && reg_addr == OFS_CLOCK_CONTROL |=>
        timing.module_clock_select == $past(reg_wdata[POS_CLOCK_SELECT]))
        else $error("clock select wrong");
    chk_irq_masked: assert property (reg_write && reg_addr == OFS_EVENT_ENABLES &&
        (reg_wdata[7:0] & EVENT_MASK) == 8'h00 |=> !irq) else $error("irq while masked");
    cover property (irq);
    cover property (events.wakeup);
    cover property (reg_write && reg_addr == OFS_BIT_TIMING_ONE);
endmodule : csb_status_regs_asserts
bind csb_status_regs csb_status_regs_asserts chk (.*);

// ==== tb/csb_engine_model.sv ====
// Model of the protocol engine and buffer logic that feed the block
`timescale 1ns/1ps
module csb_engine_model import csb_pkg::*; (
    // Clock
    input wire logic sys_clk,
    // Status and events towards the block
    output logic [5:0] fifo_write_pointer, fifo_next_read_pointer,
    output logic [7:0] tx_error_counter, rx_error_counter,
    output csb_err_state_type err_state,
    output csb_events_type events
);
    initial begin
        {fifo_write_pointer, fifo_next_read_pointer, err_state, events} = '0;
        {tx_error_counter, rx_error_counter} = 16'h0000;
    end
    task automatic set_levels(input logic [32:0] v);
        @(posedge sys_clk);
        {fifo_write_pointer, fifo_next_read_pointer, err_state} <= v[32:16];
        {tx_error_counter, rx_error_counter} <= v[15:0];
    endtask : set_levels
    // Events last exactly one cycle
    task automatic pulse(input logic [5:0] ev);
        @(posedge sys_clk);
        events <= ev;
        @(posedge sys_clk);
        events <= '0;
    endtask : pulse
endmodule : csb_engine_model

// ==== tb/csb_status_regs_tb.sv ====
// Self-checking bench for the status, event and bit-timing registers
`timescale 1ns/1ps
module csb_status_regs_tb;
    import csb_pkg::*;
    logic sys_clk = 1'b0, reset = 1'b1, reg_write = 1'b0, reg_read = 1'b0, irq;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata;
    logic [5:0] fifo_write_pointer, fifo_next_read_pointer;
    logic [7:0] tx_error_counter, rx_error_counter;
    csb_err_state_type err_state;
    csb_events_type events;
    csb_timing_type timing;
    int n_fail = 0, total_checks = 0, cycles = 0;
    always #20 sys_clk = ~sys_clk;
    csb_engine_model model (.*);
    csb_status_regs uut (.*);
    task automatic chk(input string nm, input logic [15:0] got, exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge sys_clk);
        {reg_write, reg_addr, reg_wdata} <= {1'b1, a, v};
        @(posedge sys_clk);
        reg_write <= 1'b0;
        #1;
    endtask : wr
    task automatic rc(input logic [3:0] a, input logic [15:0] exp, input string nm);
        @(posedge sys_clk);
        {reg_read, reg_addr} <= {1'b1, a};
        @(posedge sys_clk);
        reg_read <= 1'b0;
        #1 chk(nm, reg_rdata, exp);
    endtask : rc
    task automatic tally_and_finish();
        if (n_fail == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : tally_and_finish
    task automatic t_status();
        // Fields: write ptr, read ptr, state, tx count, rx count
        model.set_levels({6'h1F, 6'h0A, 5'h00, 8'hA5, 8'h5A});
        wr(OFS_FIFO_STATUS, 16'hFFFF);
        rc(OFS_FIFO_STATUS, 16'h1F0A, "fifo");
        rc(OFS_ERROR_COUNTERS, 16'hA55A, "counters");
        rc(4'hF, 16'h0000, "unmapped");
    endtask : t_status
    task automatic t_err();
        for (int i = 0; i < 5; i++) begin
            model.set_levels({17'(1 << i), 16'h0000});
            @(posedge sys_clk);
            rc(OFS_EVENT_FLAGS, {2'h0, 5'(1 << i), i < 2, 8'h20}, "state");
            wr(OFS_EVENT_FLAGS, 16'h0000);
            model.set_levels(33'h000000000);
            rc(OFS_EVENT_FLAGS, 16'h0000, "state gone");
        end
    endtask : t_err
    task automatic t_events();
        rc(OFS_EVENT_ENABLES, 16'h0000, "enables reset");
        wr(OFS_EVENT_ENABLES, 16'hFFFF);
        rc(OFS_EVENT_ENABLES, 16'h00EF, "enables");
        for (int i = 0; i < 6; i++) begin
            model.pulse(6'(1 << i));
            wr(OFS_EVENT_FLAGS, 16'hFFFF);
            rc(OFS_EVENT_FLAGS, 16'(1 << (i > 3 ? i + 2 : i)), "event");
            chk("irq on", 16'(irq), 16'h0001);
            fork
                wr(OFS_EVENT_FLAGS, 16'h0000);
                model.pulse(6'(1 << i));
            join
            rc(OFS_EVENT_FLAGS, 16'(1 << (i > 3 ? i + 2 : i)), "set wins");
            wr(OFS_EVENT_FLAGS, 16'h0000);
            chk("irq off", 16'(irq), 16'h0000);
        end
        wr(OFS_EVENT_ENABLES, 16'h0000);
    endtask : t_events
    task automatic t_timing();
        chk("quanta reset", 16'(timing), 16'h0204);
        wr(OFS_BIT_TIMING_ONE, 16'hFFFF);
        rc(OFS_BIT_TIMING_ONE, 16'h00FF, "timing");
        chk("quanta max", 16'(timing), 16'h0900);
        wr(OFS_BIT_TIMING_ONE, 16'h0081);
        chk("quanta mid", 16'(timing), 16'h0608);
        wr(OFS_CLOCK_CONTROL, 16'h0001);
        chk("clock select low", 16'(timing.module_clock_select), 16'h0000);
        wr(OFS_CLOCK_CONTROL, 16'hFFFF);
        chk("clock select", 16'(timing.module_clock_select), 16'h0001);
        rc(OFS_CLOCK_CONTROL, 16'h0800, "clock reg");
    endtask : t_timing
    initial begin
        repeat (4) @(posedge sys_clk);
        reset <= 1'b0;
        t_timing();
        t_status();
        t_err();
        t_events();
        tally_and_finish();
    end
    // Guards against a hang in any handshake
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_fail++;
            tally_and_finish();
        end
    end
endmodule : csb_status_regs_tb
